// [design/ddr4_ca_bus.sv]
/*
  Command and address pin driver for one DDR4 channel: encodes commands
  onto the upper address lines, drives bank group and bank, parity,
  captures parity alerts during training and drives the termination gate.
  Parity is even over the activate, address, bank group and bank lines;
  chip selects stay outside it.
  Assumes a controller on sys_clk issues one command per cycle with a
  valid strobe, and that power state inputs come from another domain.
*/
`default_nettype none

// What this block does
// - Activate high: top address bits carry command
// - Bits 16,15,14 are row, column, write strobes
// - Bank group names target of each command
// - Bank group bit 0 picks mode register
// - Bank field names bank within group
// - Bank field also picks mode register
// - Alert watched only during command training
// - Training alert captured as parity error flag
// - No write CRC; alert never means CRC
// - Parity output covers each command transfer
// - Termination gate high in normal operation
// - Termination gate low in C8+ or S3
// - Address bit 10 requests auto-precharge
module ddr4_ca_bus #(
  parameter int ADDR_WIDTH  = ddr4_ca_pkg::ADDR_WIDTH,
  parameter int RANK_COUNT  = ddr4_ca_pkg::RANK_COUNT
) (
  // Clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  // Command request from controller
  input  wire logic                               cmdValid,
  input  wire ddr4_ca_pkg::cmd_type               cmdKind,
  input  wire logic [$clog2(RANK_COUNT)-1:0]      cmdRank,
  input  wire logic [ADDR_WIDTH-1:0]              cmdAddr,
  input  wire logic [ddr4_ca_pkg::GROUP_WIDTH-1:0] cmdGroup,
  input  wire logic [ddr4_ca_pkg::BANK_WIDTH-1:0] cmdBank,
  input  wire logic                               cmdAutoPre,
  // Training control and status
  input  wire logic                               trainingOn,
  input  wire logic                               parityErrClear,
  output var  logic                               parityErrFlag,
  // Power state levels from another domain
  input  wire logic                               pkgIdleDeep,
  input  wire logic                               suspendS3,
  // Memory pins
  output var  logic [RANK_COUNT-1:0]              chipSelect_n,
  output var  logic                               activate_cmd_n,
  output var  logic [ADDR_WIDTH-1:0]              mem_addr_bus,
  output var  logic [ddr4_ca_pkg::GROUP_WIDTH-1:0] bank_group_sel,
  output var  logic [ddr4_ca_pkg::BANK_WIDTH-1:0] bankSel,
  output var  logic                               cmd_addr_parity,
  input  wire logic                               memAlert_n,
  output var  logic                               term_supply_gate
);

  // Pin state
  logic [RANK_COUNT-1:0]              csN_q, csN_d;
  logic                               actN_q, actN_d;
  logic [ADDR_WIDTH-1:0]              addr_q, addr_d;
  logic [ddr4_ca_pkg::GROUP_WIDTH-1:0] group_q, group_d;
  logic [ddr4_ca_pkg::BANK_WIDTH-1:0] bank_q, bank_d;
  logic                               par_q, par_d;

  function automatic logic [2:0] strobeCode(input ddr4_ca_pkg::cmd_type kind);
    case (kind)
      ddr4_ca_pkg::CMD_READ:      strobeCode = ddr4_ca_pkg::STROBE_READ;
      ddr4_ca_pkg::CMD_WRITE:     strobeCode = ddr4_ca_pkg::STROBE_WRITE;
      ddr4_ca_pkg::CMD_PRECHARGE: strobeCode = ddr4_ca_pkg::STROBE_PRECHARGE;
      ddr4_ca_pkg::CMD_MODE_SET:  strobeCode = ddr4_ca_pkg::STROBE_MODE_SET;
      ddr4_ca_pkg::CMD_REFRESH:   strobeCode = ddr4_ca_pkg::STROBE_REFRESH;
      default:                    strobeCode = ddr4_ca_pkg::STROBE_NOP;
    endcase
  endfunction

  // Slot carries a command for the memory
  function automatic logic issues(input logic valid, input ddr4_ca_pkg::cmd_type kind);
    issues = valid && (kind != ddr4_ca_pkg::CMD_NOP);
  endfunction

  // Column commands carry the auto-precharge request
  function automatic logic isColumn(input ddr4_ca_pkg::cmd_type kind);
    isColumn = (kind == ddr4_ca_pkg::CMD_READ) || (kind == ddr4_ca_pkg::CMD_WRITE);
  endfunction

  always_comb begin
    logic [2:0] code;
    code    = strobeCode(cmdKind);
    csN_d   = '1;
    actN_d  = 1'b1;
    addr_d  = '0;
    group_d = '0;
    bank_d  = '0;
    if (issues(cmdValid, cmdKind)) begin
      csN_d[cmdRank] = 1'b0;
      group_d = cmdGroup;
      bank_d  = cmdBank;
      if (cmdKind == ddr4_ca_pkg::CMD_ACTIVATE) begin
        actN_d = 1'b0;
        addr_d = cmdAddr;
      end else begin
        addr_d = cmdAddr;
        addr_d[ddr4_ca_pkg::ROW_STROBE_BIT] = code[2];
        addr_d[ddr4_ca_pkg::COL_STROBE_BIT] = code[1];
        addr_d[ddr4_ca_pkg::WRITE_EN_BIT]   = code[0];
        if (isColumn(cmdKind)) begin
          addr_d[ddr4_ca_pkg::AUTO_PRE_BIT] = cmdAutoPre;
        end
      end
    end
    // Even parity over activate, address, group and bank
    par_d = actN_d ^ (^addr_d) ^ (^group_d) ^ (^bank_d);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csN_q   <= '1;
      actN_q  <= 1'b1;
      addr_q  <= '0;
      group_q <= '0;
      bank_q  <= '0;
      // Idle pins hold a single one, so even parity rests high
      par_q   <= 1'b1;
    end else begin
      csN_q   <= csN_d;
      actN_q  <= actN_d;
      addr_q  <= addr_d;
      group_q <= group_d;
      bank_q  <= bank_d;
      par_q   <= par_d;
    end
  end

  assign chipSelect_n    = csN_q;
  assign activate_cmd_n  = actN_q;
  assign mem_addr_bus    = addr_q;
  assign bank_group_sel  = group_q;
  assign bankSel         = bank_q;
  assign cmd_addr_parity = par_q;

  // Pin and power state synchronisers
  logic [2:0] pinsSync;

  ddr4_ca_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .asyncIn  ({memAlert_n, pkgIdleDeep, suspendS3}),
    .resetVal (3'h4),
    .syncOut  (pinsSync)
  );

  logic alertLow;
  logic lowPower;
  assign alertLow = ~pinsSync[2];
  assign lowPower = pinsSync[1] | pinsSync[0];

  // Alert capture: low must hold ALERT_MIN_CYC cycles during training
  localparam int CNT_W = $clog2(ddr4_ca_pkg::ALERT_MIN_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(ddr4_ca_pkg::ALERT_MIN_CYC);

  logic [CNT_W-1:0] alertCnt_q, alertCnt_d;
  logic             err_q, err_d;
  logic             gate_q, gate_d;
  logic             alertHit;

  always_comb begin
    alertCnt_d = '0;
    if (trainingOn && alertLow) begin
      alertCnt_d = (alertCnt_q == CNT_TOP) ? alertCnt_q : alertCnt_q + CNT_W'(1);
    end
    alertHit = trainingOn && alertLow && (alertCnt_d == CNT_TOP);
    // Set wins over clear; alert only ever means parity, no CRC path
    err_d = err_q;
    if (parityErrClear) begin
      err_d = 1'b0;
    end
    if (alertHit) begin
      err_d = 1'b1;
    end
    gate_d = ~lowPower;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alertCnt_q <= '0;
      err_q      <= ddr4_ca_pkg::ERR_RESET;
      gate_q     <= ddr4_ca_pkg::GATE_RESET;
    end else begin
      alertCnt_q <= alertCnt_d;
      err_q      <= err_d;
      gate_q     <= gate_d;
    end
  end

  assign parityErrFlag    = err_q;
  assign term_supply_gate = gate_q;

  // Command encoding checks
  a_cmd_strobes: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_READ |=> activate_cmd_n &&
    mem_addr_bus[16:14] == 3'h5) else $error("read strobe wrong");
  a_act_low: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_ACTIVATE |=> !activate_cmd_n &&
    mem_addr_bus == $past(cmdAddr)) else $error("activate address wrong");
  a_act_origin: assert property (@(posedge sys_clk) disable iff (rst)
    !activate_cmd_n |-> $past(cmdValid && cmdKind == ddr4_ca_pkg::CMD_ACTIVATE))
    else $error("activate without request");
  a_write_code: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_WRITE |=> mem_addr_bus[16:14] == 3'h4)
    else $error("write strobe wrong");
  a_precharge_code: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_PRECHARGE |=> activate_cmd_n &&
    mem_addr_bus[16:14] == 3'h2) else $error("precharge strobe wrong");
  a_mode_code: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_MODE_SET |=> activate_cmd_n &&
    mem_addr_bus[16:14] == 3'h0) else $error("mode set strobe wrong");
  a_refresh_code: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_REFRESH |=> activate_cmd_n &&
    mem_addr_bus[16:14] == 3'h1) else $error("refresh strobe wrong");
  a_strobe_legal: assert property (@(posedge sys_clk) disable iff (rst)
    activate_cmd_n && !(&chipSelect_n) |-> mem_addr_bus[16:14] != 3'h7)
    else $error("selected slot without command code");
  a_rank_select: assert property (@(posedge sys_clk) disable iff (rst)
    issues(cmdValid, cmdKind) |=> !chipSelect_n[$past(cmdRank)] &&
    $countones(chipSelect_n) == RANK_COUNT - 1) else $error("rank select wrong");
  a_idle_pins: assert property (@(posedge sys_clk) disable iff (rst)
    !issues(cmdValid, cmdKind) |=> &chipSelect_n && activate_cmd_n &&
    mem_addr_bus == '0 && bank_group_sel == '0 && bankSel == '0)
    else $error("idle pins wrong");
  a_group_bank: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind != ddr4_ca_pkg::CMD_NOP |=> bank_group_sel == $past(cmdGroup))
    else $error("bank group wrong");
  a_mode_select: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_MODE_SET |=> bankSel == $past(cmdBank) &&
    bank_group_sel[0] == $past(cmdGroup[0])) else $error("mode select wrong");
  a_bank_sel: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind != ddr4_ca_pkg::CMD_NOP |=> bankSel == $past(cmdBank))
    else $error("bank wrong");
  a_auto_pre: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_READ |=> mem_addr_bus[10] == $past(cmdAutoPre))
    else $error("auto precharge wrong");
  a_write_pre: assert property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_WRITE |=> mem_addr_bus[10] == $past(cmdAutoPre))
    else $error("write auto precharge wrong");
  a_pre_plain: assert property (@(posedge sys_clk) disable iff (rst)
    issues(cmdValid, cmdKind) && !isColumn(cmdKind) |=>
    mem_addr_bus[10] == $past(cmdAddr[10])) else $error("address bit 10 altered");
  a_addr_pass: assert property (@(posedge sys_clk) disable iff (rst)
    issues(cmdValid, cmdKind) |=> mem_addr_bus[9:0] == $past(cmdAddr[9:0]))
    else $error("low address bits altered");
  a_parity_even: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_addr_parity == (activate_cmd_n ^ (^mem_addr_bus) ^ (^bank_group_sel) ^ (^bankSel)))
    else $error("parity wrong");

  // Alert flag checks
  a_alert_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    !trainingOn && !parityErrFlag ##1 !trainingOn |-> !parityErrFlag)
    else $error("alert taken outside training");
  a_alert_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    !trainingOn |=> alertCnt_q == '0)
    else $error("alert counted outside training");
  a_alert_training: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(parityErrFlag) |-> $past(trainingOn))
    else $error("flag set outside training");
  a_alert_capture: assert property (@(posedge sys_clk) disable iff (rst)
    (trainingOn && !memAlert_n && !parityErrClear) [*5] |-> ##[0:4] parityErrFlag)
    else $error("alert not captured");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    alertHit |=> parityErrFlag)
    else $error("alert hit lost");
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    parityErrFlag && !parityErrClear |=> parityErrFlag)
    else $error("flag dropped without clear");
  a_err_clear: assert property (@(posedge sys_clk) disable iff (rst)
    parityErrClear && !trainingOn |=> !parityErrFlag)
    else $error("flag not cleared");

  // Power gate checks
  a_gate_off: assert property (@(posedge sys_clk) disable iff (rst)
    (suspendS3 || pkgIdleDeep) [*4] |-> !term_supply_gate)
    else $error("gate not off");
  a_gate_on: assert property (@(posedge sys_clk) disable iff (rst)
    (!suspendS3 && !pkgIdleDeep) [*4] |-> term_supply_gate)
    else $error("gate not on");

  // Scenario covers
  c_activate: cover property (@(posedge sys_clk) disable iff (rst)
    !activate_cmd_n ##1 mem_addr_bus[16:14] == 3'h5);
  c_mode_set: cover property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_MODE_SET);
  c_parity_err: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(parityErrFlag));
  c_gate_off: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(term_supply_gate));
  c_auto_pre: cover property (@(posedge sys_clk) disable iff (rst)
    cmdValid && cmdKind == ddr4_ca_pkg::CMD_WRITE && cmdAutoPre);

endmodule

`default_nettype wire

// [design/ddr4_ca_pkg.sv]
/*
  Shared constants for the DDR4 command and address pin block: address
  bit positions, command codes, timing figures and reset values.
  Assumes a 10 MHz system clock and a one-cycle command slot.
*/
`default_nettype none

package ddr4_ca_pkg;

  localparam int ADDR_WIDTH   = 17;
  localparam int BANK_WIDTH   = 2;
  localparam int GROUP_WIDTH  = 2;
  localparam int RANK_COUNT   = 2;
  localparam int ROW_STROBE_BIT  = 16;
  localparam int COL_STROBE_BIT  = 15;
  localparam int WRITE_EN_BIT    = 14;
  localparam int AUTO_PRE_BIT    = 10;

  // Command strobes {row, column, write enable}, active low on the pins
  localparam logic [2:0] STROBE_MODE_SET  = 3'h0;
  localparam logic [2:0] STROBE_REFRESH   = 3'h1;
  localparam logic [2:0] STROBE_PRECHARGE = 3'h2;
  localparam logic [2:0] STROBE_WRITE     = 3'h4;
  localparam logic [2:0] STROBE_READ      = 3'h5;
  localparam logic [2:0] STROBE_NOP       = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_MODE_SET,
    CMD_REFRESH
  } cmd_type;

  // Least time the alert pin must stay low before a parity error is taken
  localparam int  SYS_CLK_HZ      = 10_000_000;
  localparam int  ALERT_MIN_NS    = 200;
  localparam int  ALERT_MIN_CYC   = (ALERT_MIN_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic GATE_RESET     = 1'h0;
  localparam logic ERR_RESET      = 1'h0;

endpackage

`default_nettype wire

// [design/ddr4_ca_sync.sv]
/*
  Two-flop synchroniser bank for pins that arrive from outside sys_clk.
  Assumes the inputs are slow levels; nothing but the second stage is read.
*/
`default_nettype none

module ddr4_ca_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetVal,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Q;
  logic [WIDTH-1:0] stage2Q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1Q <= '0;
      stage2Q <= '0;
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
    end
  end

  // Reset value stands until both stages hold sampled pin levels
  logic [1:0] filled_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filled_q <= 2'h0;
    end else begin
      filled_q <= {filled_q[0], 1'b1};
    end
  end

  assign syncOut = filled_q[1] ? stage2Q : resetVal;

endmodule

`default_nettype wire

// [verification/ddr4_ca_bus_test.sv]
/*
  Self-checking bench for the command and address pin driver.
  Assumes the memory model answers parity faults on the alert pin.
*/
`default_nettype none

module ddr4_ca_bus_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, cmdValid = 0, cmdAutoPre = 0, trainingOn = 0;
  logic parityErrClear = 0, pkgIdleDeep = 0, suspendS3 = 0, flipPar = 0;
  ddr4_ca_pkg::cmd_type cmdKind = ddr4_ca_pkg::CMD_NOP;
  logic [0:0]  cmdRank = 0;
  logic [16:0] cmdAddr = 0, mem_addr_bus;
  logic [1:0]  cmdGroup = 0, cmdBank = 0, chipSelect_n, bank_group_sel, bankSel;
  logic        parityErrFlag, activate_cmd_n, cmd_addr_parity, memAlert_n, term_supply_gate;
  logic [25:0] expPrev;
  int          num_errors = 0, checked = 0;

  always #50 sys_clk = ~sys_clk;

  ddr4_ca_bus ddr4_ca_bus_inst (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdRank(cmdRank), .cmdAddr(cmdAddr), .cmdGroup(cmdGroup),
    .cmdBank(cmdBank), .cmdAutoPre(cmdAutoPre), .trainingOn(trainingOn),
    .parityErrClear(parityErrClear), .parityErrFlag(parityErrFlag),
    .pkgIdleDeep(pkgIdleDeep), .suspendS3(suspendS3), .chipSelect_n(chipSelect_n),
    .activate_cmd_n(activate_cmd_n), .mem_addr_bus(mem_addr_bus),
    .bank_group_sel(bank_group_sel), .bankSel(bankSel), .cmd_addr_parity(cmd_addr_parity),
    .memAlert_n(memAlert_n), .term_supply_gate(term_supply_gate));

  ddr4_mem_model ddr4_mem_model_inst (.sys_clk(sys_clk), .rst(rst),
    .chipSelect_n(chipSelect_n), .activate_cmd_n(activate_cmd_n),
    .mem_addr_bus(mem_addr_bus), .bank_group_sel(bank_group_sel), .bankSel(bankSel),
    .cmd_addr_parity(cmd_addr_parity), .flipPar(flipPar), .memAlert_n(memAlert_n));

  // Top bit marks an idle slot, where only selects, activate and address count
  function automatic logic [25:0] calcPins(logic v, ddr4_ca_pkg::cmd_type k, logic r,
                                           logic [16:0] a, logic [1:0] g, logic [1:0] b,
                                           logic ap);
    logic [16:0] ad;
    logic        actN;
    logic [2:0]  s;
    if (!v || k == ddr4_ca_pkg::CMD_NOP) return {1'h1, 2'h3, 1'h1, 22'h0};
    actN = (k != ddr4_ca_pkg::CMD_ACTIVATE);
    ad = a;
    case (k)
      ddr4_ca_pkg::CMD_READ:      s = ddr4_ca_pkg::STROBE_READ;
      ddr4_ca_pkg::CMD_WRITE:     s = ddr4_ca_pkg::STROBE_WRITE;
      ddr4_ca_pkg::CMD_PRECHARGE: s = ddr4_ca_pkg::STROBE_PRECHARGE;
      ddr4_ca_pkg::CMD_MODE_SET:  s = ddr4_ca_pkg::STROBE_MODE_SET;
      default:                    s = ddr4_ca_pkg::STROBE_REFRESH;
    endcase
    if (actN) begin
      ad[ddr4_ca_pkg::ROW_STROBE_BIT -: 3] = s;
      if (k == ddr4_ca_pkg::CMD_READ || k == ddr4_ca_pkg::CMD_WRITE) ad[10] = ap;
    end
    return {1'h0, ~(2'h1 << r), actN, ad, g, b, ^{actN, ad, g, b}};
  endfunction

  task automatic compare(input logic [24:0] got, input logic [24:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Drives one slot and checks the pins of the slot before it
  task automatic slot(input logic v, input ddr4_ca_pkg::cmd_type k, input logic r,
                      input logic [16:0] a, input logic [1:0] g, input logic [1:0] b,
                      input logic ap);
    logic [25:0] e;
    logic [24:0] m;
    @(posedge sys_clk);
    e = expPrev;
    cmdValid   <= v;
    cmdKind    <= k;
    cmdRank    <= r;
    cmdAddr    <= a;
    cmdGroup   <= g;
    cmdBank    <= b;
    cmdAutoPre <= ap;
    expPrev = calcPins(v, k, r, a, g, b, ap);
    m = e[25] ? 25'h1FFFFE0 : 25'h1FFFFFF;
    #1 compare({chipSelect_n, activate_cmd_n, mem_addr_bus, bank_group_sel, bankSel,
                cmd_addr_parity} & m, e[24:0] & m);
  endtask

  task automatic waitFlag(input logic exp);
    repeat (10) slot(0, ddr4_ca_pkg::CMD_NOP, 0, 0, 0, 0, 0);
    compare({24'h0, parityErrFlag}, {24'h0, exp});
    @(posedge sys_clk) parityErrClear <= 1;
    @(posedge sys_clk) parityErrClear <= 0;
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict;
  end

  initial begin
    void'($urandom(32'h7D54));
    expPrev = calcPins(0, ddr4_ca_pkg::CMD_NOP, 0, 0, 0, 0, 0);
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    repeat (4) @(posedge sys_clk);
    #1 compare({24'h0, term_supply_gate}, 25'h1);
    for (int k = 0; k < 7; k++) begin
      slot(1, ddr4_ca_pkg::cmd_type'(k), 1, 17'h1FFFF, 2'h3, 2'h3, 1);
      slot(1, ddr4_ca_pkg::cmd_type'(k), 0, 17'h00000, 2'h1, 2'h2, 0);
    end
    for (int i = 0; i < 300; i++)
      slot($urandom_range(7) != 0, ddr4_ca_pkg::cmd_type'($urandom_range(6)),
           1'($urandom_range(1)), 17'($urandom), 2'($urandom), 2'($urandom),
           1'($urandom));
    $display("Command encoding test done");
    for (int t = 1; t >= 0; t--) begin
      trainingOn <= t[0];
      slot(1, ddr4_ca_pkg::CMD_READ, 0, 17'h00123, 2'h2, 2'h1, 1);
      slot(0, ddr4_ca_pkg::CMD_NOP, 0, 0, 0, 0, 0);
      // Corrupt parity only while the read stands on the pins
      flipPar <= 1;
      slot(0, ddr4_ca_pkg::CMD_NOP, 0, 0, 0, 0, 0);
      flipPar <= 0;
      waitFlag(t[0]);
    end
    $display("Alert test done");
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk) {pkgIdleDeep, suspendS3} <= (p == 0) ? 2'h2 : 2'h1;
      repeat (5) @(posedge sys_clk);
      #1 compare({24'h0, term_supply_gate}, 25'h0);
      @(posedge sys_clk) {pkgIdleDeep, suspendS3} <= 2'h0;
      repeat (5) @(posedge sys_clk);
      #1 compare({24'h0, term_supply_gate}, 25'h1);
    end
    $display("Power gate test done");
    print_verdict;
  end
endmodule

`default_nettype wire

// [verification/ddr4_mem_model.sv]
/*
  Behavioural memory rank on the command pins: checks even parity on
  every selected cycle while the alert pin is released, and pulls the alert pin low for a while on a hit.
  Assumes pins are sampled on sys_clk; flipPar corrupts the sampled parity.
*/
`default_nettype none

module ddr4_mem_model #(
  parameter int ALERT_CYC = 6
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Command pins
  input  wire logic [1:0]  chipSelect_n,
  input  wire logic        activate_cmd_n,
  input  wire logic [16:0] mem_addr_bus,
  input  wire logic [1:0]  bank_group_sel,
  input  wire logic [1:0]  bankSel,
  input  wire logic        cmd_addr_parity,
  input  wire logic        flipPar,
  // Alert pin, pulled up when released
  output var  logic        memAlert_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int lowCnt;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lowCnt <= 0;
    end else if (lowCnt > 0) begin
      lowCnt <= lowCnt - 1;
    end else if (!(&chipSelect_n) && (^{activate_cmd_n, mem_addr_bus, bank_group_sel,
                 bankSel, cmd_addr_parity, flipPar})) begin
      lowCnt <= ALERT_CYC;
    end
  end

  assign memAlert_n = (lowCnt == 0);
endmodule

`default_nettype wire
